// [design/ext_word_mem.sv]
/*
  word memory behind the extended space, with byte lanes and a registered read.
  assumes one clock and a request held for a single cycle.
*/
`timescale 1ns/1ps
module ext_word_mem #(
  parameter int DEPTH_W = 6
) (
  // clock
  input wire logic clk,
  // request
  input wire logic en,
  input wire logic [1:0] we,
  input wire logic [DEPTH_W-1:0] addr,
  input wire logic [15:0] wdata,
  // answer
  output logic [15:0] rdata
);
  logic [15:0] mem [0:(1<<DEPTH_W)-1];

  // byte lane writes and registered read of the old word
  always_ff @(posedge clk) begin
    if (en) begin
      if (we[0]) begin
        mem[addr][7:0] <= wdata[7:0];
      end
      if (we[1]) begin
        mem[addr][15:8] <= wdata[15:8];
      end
      rdata <= mem[addr];
    end
  end
endmodule : ext_word_mem

// [design/host_port_indirect_access.sv]
/*
  asynchronous 8-bit host port: two bus styles, muxed or separate address,
  interrupt grouping and handshaked 16-bit indirect access to the extended space.
  assumes host pins are asynchronous and event inputs come from logic on clk.
*/
`timescale 1ns/1ps
// Notes on behaviour
// R1: style strap high selects strobe-acknowledge style
// R2: mux strap high selects multiplexed address/data
// R3: muxed: data carries address, a0 latches it
// R4: answer only with select low; data released otherwise
// R5: host: direction high reads, strobe times access
// R6: acknowledge low on completion, high, then released
// R7: host: read-enable low reads, write-enable low writes
// R8: ready high on completion, released when idle
// R9: interrupt polarity follows the selected bus style; irq_out is low in reset and until the strap is synchronised, in either style
// R10: each status bit has an enable gating interrupts
// R11: service register shows enabled group requests
// R12: control cell events use own service bits
// R13: control cell status sets even when disabled
// R14: byte registers direct, 16-bit space indirect
// R15: word access, upper 20 address bits supplied
// R16: host writes address, data, then access with go
// R17: host reads: access with code zero, then data
// R18: go clears at end; host polls access only
// R19: host finishes start-up before extended access
// R20: extended completion is the clearing of go
// R21: write code selects low, high or both lanes
module host_port_indirect_access import host_port_pkg::*; #(
  parameter int DEPTH_W = 6
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // static straps
  input wire logic mot_sel,
  input wire logic mux_sel,
  // host bus pins
  input wire logic sel_n,
  input wire logic write_or_strobe_n,
  input wire logic read_or_dir,
  input wire logic [7:0] addr_in,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic data_oe,
  output logic ready_out,
  output logic ready_oe,
  output logic irq_out,
  // interrupt events from the register groups
  input wire logic main_event,
  input wire logic cell_event,
  input wire logic buf_event,
  input wire logic cell_sent_event,
  input wire logic control_cell_waiting_event
);
  logic [PIN_W-1:0] s1_r, s2_r, s3_r, pin_r, pin_nxt;
  logic p_mot, p_mux, p_sel_n, p_wr, p_rd, active, is_rd;
  logic [7:0] p_a, p_d, addr_eff, rd_val;
  logic [7:0] alat_r, alat_nxt, dout_r, dout_nxt;
  logic doe_r, doe_nxt, rdy_r, rdy_nxt, roe_r, roe_nxt, irq_r, irq_nxt;
  host_state_t st_r, st_nxt;
  logic [SRV_W-1:0] stat_r, stat_nxt, en_r, en_nxt, srv_r, srv_nxt, clr;
  logic a4_r, a4_nxt;
  logic [2:0] a1_r, a1_nxt;
  logic [7:0] a3_r, a3_nxt, a2_r, a2_nxt, acc_r, acc_nxt, dh_r, dh_nxt, dl_r, dl_nxt;
  ext_state_t ex_r, ex_nxt;
  logic wr_hit, mem_en;
  logic [EXT_ADDR_W-1:0] ext_addr;
  logic [15:0] mem_rdata;

  // three-stage synchroniser, a bit counts once stages two and three agree
  always_comb begin
    pin_nxt = (s2_r & s3_r) | (pin_r & (s2_r | s3_r));
  end
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s1_r <= PIN_IDLE; // all stages idle, so no false access while they fill
      s2_r <= PIN_IDLE;
      s3_r <= PIN_IDLE;
      pin_r <= PIN_IDLE;
    end else begin
      s1_r <= {mot_sel, mux_sel, sel_n, write_or_strobe_n, read_or_dir, addr_in, data_in};
      s2_r <= s1_r;
      s3_r <= s2_r;
      pin_r <= pin_nxt;
    end
  end

  // decode of the clean pins
  assign p_mot = pin_r[20]; // R1
  assign p_mux = pin_r[19]; // R2
  assign p_sel_n = pin_r[18];
  assign p_wr = pin_r[17];
  assign p_rd = pin_r[16];
  assign p_a = pin_r[15:8];
  assign p_d = pin_r[7:0];
  assign addr_eff = p_mux ? alat_r : p_a; // R3
  assign active = !p_sel_n && (p_mot ? !p_wr : (!p_rd || !p_wr)); // R4 R5 R7
  assign is_rd = p_mot ? p_rd : !p_rd; // R5 R7
  assign wr_hit = (st_r == ST_IDLE) && active && !is_rd;
  assign ext_addr = {a4_r, a3_r, a2_r, a1_r, acc_r[ACC_A_W-1:0]}; // R15
  assign mem_en = (ex_r == EX_ISSUE);

  // direct register read, unmapped bytes read zero
  always_comb begin
    unique case (addr_eff)
      SRV_REQ_ADDR: rd_val = {3'h0, srv_r}; // R11
      EXT_A4_ADDR: rd_val = {7'h00, a4_r};
      EXT_A3_ADDR: rd_val = a3_r;
      EXT_A2_ADDR: rd_val = a2_r;
      EXT_A1_ADDR: rd_val = {5'h00, a1_r};
      EXT_ACC_ADDR: rd_val = acc_r; // R18
      EXT_DH_ADDR: rd_val = dh_r;
      EXT_DL_ADDR: rd_val = dl_r;
      INT_STAT_ADDR: rd_val = {3'h0, stat_r};
      INT_EN_ADDR: rd_val = {3'h0, en_r};
      default: rd_val = REG_RST; // R14
    endcase
  end

  // host cycle handshake and pin drivers
  always_comb begin
    st_nxt = st_r;
    dout_nxt = dout_r;
    doe_nxt = doe_r;
    rdy_nxt = rdy_r;
    roe_nxt = roe_r;
    alat_nxt = (p_mux && p_a[0]) ? p_d : alat_r; // R3
    unique case (st_r)
      ST_IDLE: begin
        if (active) begin
          st_nxt = ST_ACK;
          dout_nxt = rd_val;
          doe_nxt = is_rd;
          rdy_nxt = !p_mot; // R6 R8
          roe_nxt = 1'b1;
        end
      end
      ST_ACK: begin
        if (!active) begin
          doe_nxt = 1'b0; // R4
          if (p_mot) begin
            st_nxt = ST_REL;
            rdy_nxt = 1'b1; // R6
          end else begin
            st_nxt = ST_IDLE;
            roe_nxt = 1'b0; // R8
          end
        end
      end
      ST_REL: begin
        st_nxt = ST_IDLE;
        roe_nxt = 1'b0; // R6
      end
    endcase
  end
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_r <= ST_IDLE;
      dout_r <= REG_RST;
      doe_r <= 1'b0;
      rdy_r <= 1'b0;
      roe_r <= 1'b0;
      alat_r <= REG_RST;
    end else begin
      st_r <= st_nxt;
      dout_r <= dout_nxt;
      doe_r <= doe_nxt;
      rdy_r <= rdy_nxt;
      roe_r <= roe_nxt;
      alat_r <= alat_nxt;
    end
  end

  // interrupt status, enables and service request; a set beats a clear
  always_comb begin
    clr = (wr_hit && addr_eff == INT_STAT_ADDR) ? p_d[SRV_W-1:0] : '0;
    stat_nxt = (stat_r & ~clr) | {control_cell_waiting_event, cell_sent_event,
                                   buf_event, cell_event, main_event}; // R13
    en_nxt = (wr_hit && addr_eff == INT_EN_ADDR) ? p_d[SRV_W-1:0] : en_r; // R10
    srv_nxt = stat_nxt & en_nxt; // R10 R11 R12
    irq_nxt = p_mot ? !(|srv_nxt) : |srv_nxt; // R9
  end
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      stat_r <= '0;
      en_r <= '0;
      srv_r <= '0;
      irq_r <= 1'b0;
    end else begin
      stat_r <= stat_nxt;
      en_r <= en_nxt;
      srv_r <= srv_nxt;
      irq_r <= irq_nxt;
    end
  end

  // extended address, data and access registers and their sequencer
  always_comb begin
    ex_nxt = ex_r;
    a4_nxt = a4_r;
    a3_nxt = a3_r;
    a2_nxt = a2_r;
    a1_nxt = a1_r;
    acc_nxt = acc_r;
    dh_nxt = dh_r;
    dl_nxt = dl_r;
    if (wr_hit && ex_r == EX_IDLE) begin
      unique case (addr_eff)
        EXT_A4_ADDR: a4_nxt = p_d[0];
        EXT_A3_ADDR: a3_nxt = p_d;
        EXT_A2_ADDR: a2_nxt = p_d;
        EXT_A1_ADDR: a1_nxt = p_d[2:0];
        EXT_DH_ADDR: dh_nxt = p_d;
        EXT_DL_ADDR: dl_nxt = p_d;
        EXT_ACC_ADDR: begin
          acc_nxt = p_d;
          if (p_d[ACC_GO_BIT]) begin
            ex_nxt = EX_ISSUE; // R16 R17
          end
        end
        default: ;
      endcase
    end
    unique case (ex_r)
      EX_IDLE: ;
      EX_ISSUE: ex_nxt = EX_LOAD;
      EX_LOAD: begin
        if (acc_r[ACC_WE_LSB +: 2] == WE_READ) begin
          dh_nxt = mem_rdata[15:8]; // R17
          dl_nxt = mem_rdata[7:0];
        end
        acc_nxt[ACC_GO_BIT] = 1'b0; // R18 R20
        ex_nxt = EX_IDLE;
      end
    endcase
  end
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ex_r <= EX_IDLE;
      a4_r <= 1'b0;
      a3_r <= REG_RST;
      a2_r <= REG_RST;
      a1_r <= 3'h0;
      acc_r <= REG_RST;
      dh_r <= REG_RST;
      dl_r <= REG_RST;
    end else begin
      ex_r <= ex_nxt;
      a4_r <= a4_nxt;
      a3_r <= a3_nxt;
      a2_r <= a2_nxt;
      a1_r <= a1_nxt;
      acc_r <= acc_nxt;
      dh_r <= dh_nxt;
      dl_r <= dl_nxt;
    end
  end

  // word store, the write code picks the byte lanes
  ext_word_mem #(.DEPTH_W(DEPTH_W)) u_mem (
    .clk(clk),
    .en(mem_en),
    .we(acc_r[ACC_WE_LSB +: 2]), // R21
    .addr(ext_addr[DEPTH_W-1:0]), // R14
    .wdata({dh_r, dl_r}),
    .rdata(mem_rdata)
  );

  assign data_out = dout_r;
  assign data_oe = doe_r;
  assign ready_out = rdy_r;
  assign ready_oe = roe_r;
  assign irq_out = irq_r;

  // checks on the handshake, interrupts and extended access
  a_ack_low: assert property (@(posedge clk) disable iff (sys_rst) // R6
    (st_r == ST_ACK && p_mot) |-> (!rdy_r && roe_r))
    else $error("acknowledge not low during access");
  a_ready_high: assert property (@(posedge clk) disable iff (sys_rst) // R8
    (st_r == ST_ACK && !p_mot) |-> (rdy_r && roe_r))
    else $error("ready not high during access");
  a_ack_release: assert property (@(posedge clk) disable iff (sys_rst) // R6
    (st_r == ST_ACK && p_mot && !active) |=> (rdy_r && roe_r) ##1 !roe_r)
    else $error("acknowledge not returned high then released");
  a_data_hiz: assert property (@(posedge clk) disable iff (sys_rst) // R4
    (!active && st_r == ST_ACK) |=> !doe_r)
    else $error("data lines driven after deselect");
  a_irq_pol: assert property (@(posedge clk) disable iff (sys_rst) // R9
    (|srv_r) |-> (irq_r == !p_mot))
    else $error("interrupt level wrong for bus style");
  a_sent_sticky: assert property (@(posedge clk) disable iff (sys_rst) // R13
    cell_sent_event |=> stat_r[SRV_SENT])
    else $error("cell sent status not set");
  a_main_gate: assert property (@(posedge clk) disable iff (sys_rst) // R10 R11
    (!stat_r[SRV_MAIN] || !en_r[SRV_MAIN]) |-> !srv_r[SRV_MAIN])
    else $error("main request without enabled status");
  a_go_clear: assert property (@(posedge clk) disable iff (sys_rst) // R20
    $rose(ex_r == EX_ISSUE) |-> acc_r[ACC_GO_BIT] ##2 !acc_r[ACC_GO_BIT])
    else $error("go bit not cleared two cycles after start");
  a_read_load: assert property (@(posedge clk) disable iff (sys_rst) // R17
    (ex_r == EX_LOAD && acc_r[6:5] == WE_READ) |=> ({dh_r, dl_r} == $past(mem_rdata)))
    else $error("read data not loaded");
  a_mux_latch: assert property (@(posedge clk) disable iff (sys_rst) // R3
    (p_mux && p_a[0]) |=> (alat_r == $past(p_d)))
    else $error("multiplexed address not latched");
endmodule : host_port_indirect_access

// [design/host_port_pkg.sv]
/*
  shared constants for the host port: direct register offsets, field positions,
  write codes, pin picture width and state encodings.
  assumes nothing beyond a SystemVerilog compiler.
*/
package host_port_pkg;
  // direct register offsets
  localparam logic [7:0] SRV_REQ_ADDR = 8'h29;
  localparam logic [7:0] EXT_A4_ADDR = 8'h30;
  localparam logic [7:0] EXT_A3_ADDR = 8'h31;
  localparam logic [7:0] EXT_A2_ADDR = 8'h32;
  localparam logic [7:0] EXT_A1_ADDR = 8'h33;
  localparam logic [7:0] EXT_ACC_ADDR = 8'h34;
  localparam logic [7:0] EXT_DH_ADDR = 8'h35;
  localparam logic [7:0] EXT_DL_ADDR = 8'h36;
  localparam logic [7:0] INT_STAT_ADDR = 8'h40;
  localparam logic [7:0] INT_EN_ADDR = 8'h41;
  // access register fields
  localparam int ACC_GO_BIT = 7;
  localparam int ACC_WE_LSB = 5;
  localparam int ACC_A_W = 5;
  // write codes, bit 0 updates the low byte and bit 1 the high byte
  localparam logic [1:0] WE_READ = 2'h0;
  localparam logic [1:0] WE_LOW = 2'h1;
  localparam logic [1:0] WE_HIGH = 2'h2;
  localparam logic [1:0] WE_BOTH = 2'h3;
  // interrupt status and service request bit positions
  localparam int SRV_MAIN = 0;
  localparam int SRV_CELL = 1;
  localparam int SRV_BUF = 2;
  localparam int SRV_SENT = 3;
  localparam int SRV_WAIT = 4;
  localparam int SRV_W = 5;
  // reset values and widths
  localparam logic [7:0] REG_RST = 8'h00;
  localparam int EXT_ADDR_W = 25;
  localparam int PIN_W = 21;
  // idle pin picture: straps low, select and both strobes high, buses zero
  localparam logic [PIN_W-1:0] PIN_IDLE = {2'h0, 3'h7, 16'h0000};
  // host cycle states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_ACK = 3'b010,
    ST_REL = 3'b100
  } host_state_t;
  // extended access states
  typedef enum logic [2:0] {
    EX_IDLE = 3'b001,
    EX_ISSUE = 3'b010,
    EX_LOAD = 3'b100
  } ext_state_t;
endpackage : host_port_pkg

// [test/host_bus_model.sv]
/*
  host processor model: one access at a time on the port pins, either style.
  assumes straps change only under reset and the bench calls acc and stray.
*/
`timescale 1ns/1ps
module host_bus_model (
  // clock and straps
  input wire logic clk,
  input wire logic mot,
  input wire logic mux,
  // pins toward the port
  output logic sel_n,
  output logic strobe_n,
  output logic rd_dir,
  output logic [7:0] addr,
  output logic [7:0] data,
  input wire logic [7:0] data_out,
  input wire logic data_oe,
  input wire logic ready_out,
  input wire logic ready_oe,
  // no answer or no release in time
  output logic hang
);
  logic drv = 1'b0;
  logic [7:0] wd = 8'h00;
  logic [7:0] flt = 8'h5A;
  // data wire: host, port, or a changing pattern while nobody drives it
  assign data = drv ? wd : (data_oe ? data_out : flt);
  always @(posedge clk) flt <= ~flt;
  // idle pins
  initial begin
    sel_n = 1'b1;
    strobe_n = 1'b1;
    rd_dir = 1'b1;
    addr = 8'h00;
    hang = 1'b0;
  end
  // one cycle: latch address if muxed, hold until answered, then release
  task automatic acc(input logic wr, input logic [7:0] a, input logic [7:0] d,
                     output logic [7:0] q);
    int n;
    n = 0;
    @(posedge clk);
    if (mux) begin
      addr <= 8'h01;
      wd <= a;
      drv <= 1'b1;
      repeat (8) @(posedge clk);
      addr <= 8'h00;
      @(posedge clk);
    end else begin
      addr <= a;
    end
    wd <= d;
    drv <= wr;
    sel_n <= 1'b0;
    rd_dir <= mot ? !wr : wr;
    strobe_n <= mot ? 1'b0 : !wr;
    // look at the answer where it has settled, release at the next rising edge
    @(negedge clk);
    while (!(ready_oe && ready_out == !mot) && n < 40) begin
      @(negedge clk);
      n++;
    end
    q = data;
    if (n >= 40) hang <= 1'b1;
    @(posedge clk);
    sel_n <= 1'b1;
    strobe_n <= 1'b1;
    rd_dir <= 1'b1;
    drv <= 1'b0;
    n = 0;
    @(negedge clk);
    while (ready_oe && n < 40) begin
      @(negedge clk);
      n++;
    end
    if (n >= 40) hang <= 1'b1;
  endtask : acc
  // strobe active with select high; reports any drive seen
  task automatic stray(output logic seen);
    seen = 1'b0;
    @(posedge clk);
    strobe_n <= 1'b0;
    rd_dir <= mot;
    repeat (10) begin
      @(negedge clk);
      seen = seen | data_oe | ready_oe;
    end
    @(posedge clk);
    strobe_n <= 1'b1;
    rd_dir <= 1'b1;
  endtask : stray
endmodule : host_bus_model

// [test/test_host_port_indirect_access.sv]
/*
  bench for the host port: both styles, muxed access, interrupts, extended space.
  assumes host_bus_model as the processor on the pins.
*/
`timescale 1ns/1ps
module test_host_port_indirect_access import host_port_pkg::*;;
  // clock, reset, straps, events
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic mot_sel = 1'b1;
  logic mux_sel = 1'b0;
  logic [4:0] ev = 5'h00;
  // pins and results
  logic sel_n, write_or_strobe_n, read_or_dir, data_oe, ready_out, ready_oe, irq_out, hang;
  logic seen;
  logic [7:0] addr_in, data_in, data_out, q;
  int fails = 0;
  int cmp_count = 0;
  always #12.5 clk = ~clk;
  host_port_indirect_access u_dut (.clk(clk), .sys_rst(sys_rst), .mot_sel(mot_sel),
    .mux_sel(mux_sel), .sel_n(sel_n), .write_or_strobe_n(write_or_strobe_n),
    .read_or_dir(read_or_dir), .addr_in(addr_in), .data_in(data_in), .data_out(data_out),
    .data_oe(data_oe), .ready_out(ready_out), .ready_oe(ready_oe), .irq_out(irq_out),
    .main_event(ev[0]), .cell_event(ev[1]), .buf_event(ev[2]), .cell_sent_event(ev[3]),
    .control_cell_waiting_event(ev[4]));
  host_bus_model u_host (.clk(clk), .mot(mot_sel), .mux(mux_sel), .sel_n(sel_n),
    .strobe_n(write_or_strobe_n), .rd_dir(read_or_dir), .addr(addr_in), .data(data_in),
    .data_out(data_out), .data_oe(data_oe), .ready_out(ready_out), .ready_oe(ready_oe),
    .hang(hang));
  // compare one byte
  task automatic check(input string nm, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : check
  // reset with new straps, then let the synchronisers fill
  task automatic rst(input logic m, input logic x);
    sys_rst <= 1'b1;
    mot_sel <= m;
    mux_sel <= x;
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (8) @(posedge clk);
  endtask : rst
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    u_host.acc(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    u_host.acc(1'b0, a, 8'h00, q);
  endtask : rd
  // start an extended access and poll only the access register
  task automatic go(input logic [1:0] c, input logic [4:0] a);
    wr(EXT_ACC_ADDR, {1'b1, c, a});
    rd(EXT_ACC_ADDR);
    for (int i = 0; i < 8 && q[7] !== 1'b0; i++) rd(EXT_ACC_ADDR);
    check("go bit", 8'h00, {q[7], 7'h00});
  endtask : go
  task automatic pulse(input logic [4:0] b);
    @(posedge clk);
    ev <= b;
    @(posedge clk);
    ev <= 5'h00;
    repeat (2) @(posedge clk);
  endtask : pulse
  // word write in three lane modes, then read back
  task automatic t_ext;
    rst(1'b1, 1'b0);
    wr(EXT_DH_ADDR, 8'hA5);
    wr(EXT_DL_ADDR, 8'h3C);
    go(WE_BOTH, 5'h03);
    wr(EXT_DH_ADDR, 8'h11);
    wr(EXT_DL_ADDR, 8'h22);
    go(WE_LOW, 5'h03);
    wr(EXT_DH_ADDR, 8'h77);
    wr(EXT_DL_ADDR, 8'h99);
    go(WE_HIGH, 5'h03);
    go(WE_READ, 5'h03);
    rd(EXT_DH_ADDR);
    check("data high", 8'h77, q);
    rd(EXT_DL_ADDR);
    check("data low", 8'h22, q);
    $display("test ext done");
  endtask : t_ext
  // disabled events, then each group alone
  task automatic t_irq(input logic m);
    rst(m, 1'b0);
    check("irq idle", {7'h00, m}, {7'h00, irq_out});
    pulse(5'h18);
    rd(INT_STAT_ADDR);
    check("status", 8'h18, q);
    rd(SRV_REQ_ADDR);
    check("service", 8'h00, q);
    check("irq off", {7'h00, m}, {7'h00, irq_out});
    wr(INT_STAT_ADDR, 8'h18);
    wr(INT_EN_ADDR, 8'h1F);
    for (int i = 0; i < 5; i++) begin
      pulse(5'h01 << i);
      check("irq on", {7'h00, !m}, {7'h00, irq_out});
      rd(SRV_REQ_ADDR);
      check("service", 8'h01 << i, q);
      wr(INT_STAT_ADDR, 8'h01 << i);
      check("irq clr", {7'h00, m}, {7'h00, irq_out});
    end
    $display("test irq done");
  endtask : t_irq
  // muxed bus, unmapped read, strobe without select
  task automatic t_mux;
    rst(1'b0, 1'b1);
    wr(INT_EN_ADDR, 8'h15);
    rd(INT_EN_ADDR);
    check("muxed", 8'h15, q);
    rd(8'hF0);
    check("unmapped", 8'h00, q);
    u_host.stray(seen);
    check("no select", 8'h00, {7'h00, seen});
    check("released", 8'h00, {6'h00, data_oe, ready_oe});
    check("hang", 8'h00, {7'h00, hang});
    $display("test mux done");
  endtask : t_mux
  task automatic test_done;
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : test_done
  // main sequence
  initial begin
    t_ext();
    t_irq(1'b1);
    t_irq(1'b0);
    t_mux();
    test_done();
  end
  // watchdog
  initial begin
    repeat (30000) @(posedge clk);
    fails++;
    test_done();
  end
endmodule : test_host_port_indirect_access
